/* File: core/adc_ctrl_pkg.sv */
// constants, types and field layout for the converter control block
// ============================================================
package adc_ctrl_pkg;

    // ============================================================
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0C;
    localparam logic [7:0] IDX_RESULT_HIGH = 8'h1E;
    localparam logic [7:0] IDX_CONTROL_MAIN = 8'h1F;
    localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8C;
    localparam logic [7:0] IDX_RESULT_LOW = 8'h9E;
    localparam logic [7:0] IDX_PORT_CONFIG = 8'h9F;
    localparam int unsigned BUS_ADDR_W = 10;
    localparam int unsigned BUS_IDX_LSB = 2;

    // ============================================================
    // field positions and reset values
    localparam int unsigned CM_CLKSEL_LSB = 6;
    localparam int unsigned CM_CHAN_LSB = 3;
    localparam int unsigned CM_GO_BIT = 2;
    localparam int unsigned CM_POWER_BIT = 0;
    localparam int unsigned IRQ_DONE_BIT = 6;
    localparam int unsigned PC_JUSTIFY_BIT = 7;
    localparam int unsigned PC_ANALOG_LSB = 0;
    localparam logic [7:0] CONTROL_MAIN_RST = 8'h00;
    localparam logic [7:0] PORT_CONFIG_RST = 8'h00;
    localparam logic [7:0] IRQ_REG_RST = 8'h00;

    // ============================================================
    // widths and timing
    localparam int unsigned RESULT_W = 10;
    localparam int unsigned CHAN_W = 3;
    localparam int unsigned ANALOG_CFG_W = 4;
    localparam int unsigned DIV_W = 5;
    localparam int unsigned CONV_DIV2 = 2;
    localparam int unsigned CONV_DIV8 = 8;
    localparam int unsigned CONV_DIV32 = 32;
    localparam int unsigned OSC_PER_INSTR = 4; // oscillator periods per instruction cycle
    localparam int unsigned RC_DELAY_CLKS = OSC_PER_INSTR;

    // ============================================================
    // types
    typedef enum logic [1:0] {
        CLK_DIV2 = 2'b00,
        CLK_DIV8 = 2'b01,
        CLK_DIV32 = 2'b10,
        CLK_RC = 2'b11
    } clk_sel_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DELAY = 2'b01,
        ST_CONV = 2'b11
    } conv_state_t;

    // commands to the analog core
    typedef struct packed {
        logic power;
        logic start;
        logic abort;
        logic tick;
        logic [CHAN_W-1:0] channel;
    } conv_ctrl_t;

    // pin and reference configuration
    typedef struct packed {
        logic justify;
        logic [ANALOG_CFG_W-1:0] analog_cfg;
    } port_cfg_t;

endpackage

/* File: core/adc_conv_ctrl.sv */
// converter control: registers, clock select, sequencing, sleep and interrupt
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/10ps
module adc_conv_ctrl
    import adc_ctrl_pkg::*;
#(
    parameter int unsigned NUM_CHANNELS = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // avalon-mm slave, byte address
    input wire logic [BUS_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // core state and analog side
    input wire logic sleep_i,
    input wire logic rc_osc_i,
    input wire logic conv_done_i,
    input wire logic [RESULT_W-1:0] conv_data_i,
    output conv_ctrl_t conv_ctrl,
    output port_cfg_t port_cfg,
    output logic wake,
    output logic irq
);

    // ============================================================
    // elaboration check: only the two package variants exist
    if (NUM_CHANNELS != 5 && NUM_CHANNELS != 8) begin : g_bad_channels
        $error("NUM_CHANNELS must be 5 or 8");
    end

    // ============================================================
    // state
    clk_sel_t clksel_q;
    logic [CHAN_W-1:0] chan_q;
    logic go_q;
    logic power_q;
    logic justify_q;
    logic [ANALOG_CFG_W-1:0] analog_cfg_q;
    logic flag_q;
    logic enable_q;
    logic [RESULT_W-1:0] result_q;
    conv_state_t state_q;
    logic [DIV_W-1:0] div_cnt_q;
    logic [DIV_W-1:0] delay_cnt_q;
    logic rc_sync1_q;
    logic rc_sync2_q;
    logic rc_prev_q;
    logic waitrequest_q;
    logic [31:0] readdata_q;
    conv_ctrl_t conv_ctrl_q;
    logic wake_q;
    logic irq_q;

    // ============================================================
    // bus decode
    logic [7:0] idx;
    logic req;
    logic wr_take;
    logic wr_ctrl;
    logic rc_mode;
    logic sleep_block;
    logic done_evt;
    logic abort_cond;
    logic launch;
    logic [DIV_W-1:0] div_limit;
    logic rc_edge;
    logic [7:0] rd_byte;

    assign idx = address[BUS_IDX_LSB +: 8];
    assign req = read | write;
    assign wr_take = write & ~waitrequest_q & byteenable[0];
    assign wr_ctrl = wr_take & (idx == IDX_CONTROL_MAIN);
    assign rc_mode = (clksel_q == CLK_RC);
    assign sleep_block = sleep_i & ~rc_mode;
    assign done_evt = (state_q == ST_CONV) & conv_done_i;
    assign abort_cond = ~power_q | ~go_q | sleep_block;
    assign launch = (state_q == ST_IDLE) & go_q & power_q & ~sleep_block;
    assign rc_edge = rc_sync2_q & ~rc_prev_q;

    // divider terminal count for the selected clock
    always_comb begin
        unique case (clksel_q)
            CLK_DIV2: div_limit = DIV_W'(CONV_DIV2 - 1);
            CLK_DIV8: div_limit = DIV_W'(CONV_DIV8 - 1);
            CLK_DIV32: div_limit = DIV_W'(CONV_DIV32 - 1);
            CLK_RC: div_limit = '0;
        endcase
    end

    // read mux; result bytes formatted by the justify bit
    always_comb begin
        rd_byte = 8'h00;
        unique case (idx)
            IDX_IRQ_FLAGS: rd_byte[IRQ_DONE_BIT] = flag_q;
            IDX_IRQ_ENABLES: rd_byte[IRQ_DONE_BIT] = enable_q;
            IDX_CONTROL_MAIN: begin
                rd_byte[CM_CLKSEL_LSB +: 2] = clksel_q;
                rd_byte[CM_CHAN_LSB +: CHAN_W] = chan_q;
                rd_byte[CM_GO_BIT] = go_q;
                rd_byte[CM_POWER_BIT] = power_q; // bit one stays zero
            end
            IDX_PORT_CONFIG: begin
                rd_byte[PC_JUSTIFY_BIT] = justify_q;
                rd_byte[PC_ANALOG_LSB +: ANALOG_CFG_W] = analog_cfg_q;
            end
            IDX_RESULT_HIGH: rd_byte = justify_q ? {6'h00, result_q[9:8]} : result_q[9:2];
            IDX_RESULT_LOW: rd_byte = justify_q ? result_q[7:0] : {result_q[1:0], 6'h00};
            default: rd_byte = 8'h00;
        endcase
    end

    // ============================================================
    // bus handshake: one wait cycle, then answer
    always_ff @(posedge clk) begin
        if (!nrst) begin
            waitrequest_q <= 1'b1;
            readdata_q <= 32'h0000_0000;
        end else if (ce) begin
            if (req && waitrequest_q) begin
                waitrequest_q <= 1'b0;
                readdata_q <= read ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            end else begin
                waitrequest_q <= 1'b1;
            end
        end
    end

    // ============================================================
    // main control register; go cleared by hardware
    always_ff @(posedge clk) begin
        if (!nrst) begin
            clksel_q <= clk_sel_t'(CONTROL_MAIN_RST[CM_CLKSEL_LSB +: 2]);
            chan_q <= CONTROL_MAIN_RST[CM_CHAN_LSB +: CHAN_W];
            go_q <= CONTROL_MAIN_RST[CM_GO_BIT];
            power_q <= CONTROL_MAIN_RST[CM_POWER_BIT];
        end else if (ce) begin
            if ((state_q != ST_IDLE && abort_cond) || done_evt) begin
                go_q <= 1'b0;
            end
            if (wr_ctrl) begin
                clksel_q <= clk_sel_t'(writedata[CM_CLKSEL_LSB +: 2]);
                chan_q <= writedata[CM_CHAN_LSB +: CHAN_W];
                go_q <= writedata[CM_GO_BIT] & writedata[CM_POWER_BIT];
                power_q <= writedata[CM_POWER_BIT];
            end
        end
    end

    // port configuration register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            justify_q <= PORT_CONFIG_RST[PC_JUSTIFY_BIT];
            analog_cfg_q <= PORT_CONFIG_RST[PC_ANALOG_LSB +: ANALOG_CFG_W]; // all pins analog
        end else if (ce && wr_take && idx == IDX_PORT_CONFIG) begin
            justify_q <= writedata[PC_JUSTIFY_BIT];
            analog_cfg_q <= writedata[PC_ANALOG_LSB +: ANALOG_CFG_W];
        end
    end

    // interrupt flag (write one clears, set wins) and enable
    always_ff @(posedge clk) begin
        if (!nrst) begin
            flag_q <= IRQ_REG_RST[IRQ_DONE_BIT];
            enable_q <= IRQ_REG_RST[IRQ_DONE_BIT];
        end else if (ce) begin
            if (done_evt) begin
                flag_q <= 1'b1;
            end else if (wr_take && idx == IDX_IRQ_FLAGS && writedata[IRQ_DONE_BIT]) begin
                flag_q <= 1'b0;
            end
            if (wr_take && idx == IDX_IRQ_ENABLES) begin
                enable_q <= writedata[IRQ_DONE_BIT];
            end
        end
    end

    // result holds across every reset
    always_ff @(posedge clk) begin
        if (ce && done_evt) begin
            result_q <= conv_data_i;
        end
    end

    // ============================================================
    // rc oscillator synchroniser
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rc_sync1_q <= 1'b0;
            rc_sync2_q <= 1'b0;
            rc_prev_q <= 1'b0;
        end else if (ce) begin
            rc_sync1_q <= rc_osc_i;
            rc_sync2_q <= rc_sync1_q;
            rc_prev_q <= rc_sync2_q;
        end
    end

    // conversion sequencer
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            delay_cnt_q <= '0;
        end else if (ce) begin
            unique case (state_q)
                ST_IDLE: begin
                    delay_cnt_q <= '0;
                    if (launch) begin
                        state_q <= rc_mode ? ST_DELAY : ST_CONV;
                    end
                end
                ST_DELAY: begin
                    delay_cnt_q <= delay_cnt_q + 1'b1;
                    if (abort_cond) begin
                        state_q <= ST_IDLE;
                    end else if (delay_cnt_q == DIV_W'(RC_DELAY_CLKS - 1)) begin
                        state_q <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (abort_cond || conv_done_i) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // conversion clock divider, runs only while converting
    always_ff @(posedge clk) begin
        if (!nrst) begin
            div_cnt_q <= '0;
        end else if (ce) begin
            if (state_q != ST_CONV || div_cnt_q == div_limit) begin
                div_cnt_q <= '0;
            end else begin
                div_cnt_q <= div_cnt_q + 1'b1;
            end
        end
    end

    // ============================================================
    // analog commands
    always_ff @(posedge clk) begin
        if (!nrst) begin
            conv_ctrl_q <= '0;
        end else if (ce) begin
            conv_ctrl_q.power <= power_q & ~sleep_block;
            conv_ctrl_q.channel <= chan_q;
            conv_ctrl_q.start <= (launch && !rc_mode) ||
                (state_q == ST_DELAY && !abort_cond && delay_cnt_q == DIV_W'(RC_DELAY_CLKS - 1));
            conv_ctrl_q.abort <= (state_q != ST_IDLE) && abort_cond;
            conv_ctrl_q.tick <= (state_q == ST_CONV) &&
                (rc_mode ? rc_edge : (div_cnt_q == div_limit));
        end
    end

    // wake and interrupt outputs
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wake_q <= 1'b0;
            irq_q <= 1'b0;
        end else if (ce) begin
            wake_q <= done_evt & sleep_i & enable_q;
            irq_q <= flag_q & enable_q;
        end
    end

    assign readdata = readdata_q;
    assign waitrequest = waitrequest_q;
    assign conv_ctrl = conv_ctrl_q;
    assign port_cfg = '{justify: justify_q, analog_cfg: analog_cfg_q};
    assign wake = wake_q;
    assign irq = irq_q;

    // ============================================================
    // assertions
    sequence s_conv_done;
        state_q == ST_CONV && conv_done_i;
    endsequence

    sequence s_rc_launch;
        launch && rc_mode;
    endsequence

    property p_done_loads;
        @(posedge clk) disable iff (!nrst || !ce)
        (s_conv_done and !wr_ctrl) |=> !go_q && result_q == $past(conv_data_i) && flag_q;
    endproperty
    a_done_loads: assert property (p_done_loads) else $error("done did not load result");

    property p_rc_delay;
        @(posedge clk) disable iff (!nrst || !ce)
        s_rc_launch |=> !conv_ctrl_q.start [*4];
    endproperty
    a_rc_delay: assert property (p_rc_delay) else $error("rc start came too early");

    property p_sleep_abort;
        @(posedge clk) disable iff (!nrst || !ce)
        state_q != ST_IDLE && sleep_i && !rc_mode && !wr_ctrl |=> state_q == ST_IDLE && power_q == $past(power_q)
            ##1 !conv_ctrl_q.power;
    endproperty
    a_sleep_abort: assert property (p_sleep_abort) else $error("sleep abort wrong");

    property p_no_sleep_start;
        @(posedge clk) disable iff (!nrst || !ce)
        state_q == ST_IDLE && sleep_i && !rc_mode |=> state_q == ST_IDLE;
    endproperty
    a_no_sleep_start: assert property (p_no_sleep_start) else $error("started in sleep");

    property p_wake;
        @(posedge clk) disable iff (!nrst || !ce)
        (s_conv_done and (sleep_i && enable_q)) |=> wake_q ##1 !wake_q;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on done");

    property p_irq;
        @(posedge clk) disable iff (!nrst || !ce)
        (s_conv_done and enable_q) |=> ##1 irq_q;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");

    property p_unused_bit;
        @(posedge clk) disable iff (!nrst || !ce)
        read && waitrequest_q && idx == IDX_CONTROL_MAIN |=> !readdata_q[1] && !waitrequest_q;
    endproperty
    a_unused_bit: assert property (p_unused_bit) else $error("bit one read nonzero");

    property p_power_off;
        @(posedge clk) disable iff (!nrst || !ce)
        !power_q |=> !conv_ctrl_q.power && state_q == ST_IDLE;
    endproperty
    a_power_off: assert property (p_power_off) else $error("converter on while off");

    property p_left_justify;
        @(posedge clk) disable iff (!nrst || !ce)
        read && waitrequest_q && idx == IDX_RESULT_LOW && !justify_q |=> readdata_q[5:0] == 6'h00;
    endproperty
    a_left_justify: assert property (p_left_justify) else $error("low byte not justified");

    // go can only be armed together with the power bit
    property p_go_needs_power;
        @(posedge clk) disable iff (!nrst || !ce)
        wr_ctrl && !writedata[CM_POWER_BIT] |=> !go_q;
    endproperty
    a_go_needs_power: assert property (p_go_needs_power) else $error("go set without power");

    // an abort drops go and returns the sequencer to idle
    property p_abort_clears_go;
        @(posedge clk) disable iff (!nrst || !ce)
        state_q != ST_IDLE && abort_cond && !wr_ctrl |=> !go_q && state_q == ST_IDLE;
    endproperty
    a_abort_clears_go: assert property (p_abort_clears_go) else $error("abort left go set");

    // start to the analog core is a single-cycle pulse
    property p_start_pulse;
        @(posedge clk) disable iff (!nrst || !ce)
        conv_ctrl_q.start |=> !conv_ctrl_q.start;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");

    // writing one clears the done flag when no done competes
    property p_flag_clear;
        @(posedge clk) disable iff (!nrst || !ce)
        wr_take && idx == IDX_IRQ_FLAGS && writedata[IRQ_DONE_BIT] && !done_evt |=> !flag_q;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

    property p_reset;
        @(posedge clk) $rose(nrst) |-> state_q == ST_IDLE && !conv_ctrl_q.power &&
            analog_cfg_q == PORT_CONFIG_RST[PC_ANALOG_LSB +: ANALOG_CFG_W];
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");

endmodule

/* File: tb/analog_core_model.sv */
// behavioural model of the analog multiplexer and successive approximation core
`timescale 1ns/10ps
module analog_core_model
    import adc_ctrl_pkg::*;
#(
    parameter int unsigned CONV_TICKS = 11
) (
    input wire logic clk,
    input wire logic nrst,
    input wire conv_ctrl_t conv_ctrl,
    output logic done,
    output logic [RESULT_W-1:0] data
);
    int ticks_q;
    logic busy_q;

    // ============================================================
    // conversion: start arms, the CONV_TICKS-th tick (eleven by default) completes it, abort or power off drops it
    always_ff @(posedge clk) begin
        done <= 1'b0;
        data <= ~data; // stale data toggles every cycle outside a done pulse, but sits at 10'h155 in reset, power off or abort
        if (!nrst || !conv_ctrl.power || conv_ctrl.abort) begin
            busy_q <= 1'b0;
            ticks_q <= 0;
            data <= 10'h155;
        end else if (conv_ctrl.start) begin
            busy_q <= 1'b1;
            ticks_q <= 0;
        end else if (busy_q && conv_ctrl.tick) begin
            ticks_q <= ticks_q + 1;
            if (ticks_q == CONV_TICKS - 1) begin
                busy_q <= 1'b0;
                done <= 1'b1;
                data <= {conv_ctrl.channel, 7'h2B};
            end
        end
    end
endmodule

/* File: tb/adc_conv_ctrl_tb.sv */
// self-checking bench for the converter control block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD %s expected %h seen %h", nm, e, g); end end
module adc_conv_ctrl_tb
    import adc_ctrl_pkg::*;
;
    localparam logic [9:0] A_FLAGS = 10'h030;
    localparam logic [9:0] A_HIGH = 10'h078;
    localparam logic [9:0] A_CTRL = 10'h07C;
    localparam logic [9:0] A_EN = 10'h230;
    localparam logic [9:0] A_LOW = 10'h278;
    localparam logic [9:0] A_PORT = 10'h27C;
    logic clk, nrst, ce, read, write, sleep_i, rc_osc_i, conv_done_i, wake, irq, waitrequest;
    logic [9:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata, readdata;
    logic [RESULT_W-1:0] conv_data_i, ex;
    conv_ctrl_t conv_ctrl;
    port_cfg_t port_cfg;
    int n_errors, n_tests, cyc, last_tick, gap, n_start, n_abort, n_wake, n_done, s0, w0, d0;
    int divs[3] = '{CONV_DIV2, CONV_DIV8, CONV_DIV32};
    logic [2:0] c;

    adc_conv_ctrl #(.NUM_CHANNELS(8)) u_adc_conv_ctrl (.clk(clk), .nrst(nrst), .ce(ce), .address(address),
        .read(read), .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .sleep_i(sleep_i), .rc_osc_i(rc_osc_i), .conv_done_i(conv_done_i),
        .conv_data_i(conv_data_i), .conv_ctrl(conv_ctrl), .port_cfg(port_cfg), .wake(wake), .irq(irq));
    analog_core_model u_analog_core_model (.clk(clk), .nrst(nrst), .conv_ctrl(conv_ctrl),
        .done(conv_done_i), .data(conv_data_i));

    // ============================================================
    // clocks: system clock and an unrelated internal rc oscillator
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rc_osc_i = 1'b0;
        forever #37 rc_osc_i = ~rc_osc_i;
    end

    // event monitor: tick spacing and pulse counts
    always @(posedge clk) begin
        cyc++;
        if (conv_ctrl.tick === 1'b1) begin
            gap = cyc - last_tick;
            last_tick = cyc;
        end
        if (conv_ctrl.start === 1'b1) n_start++;
        if (conv_ctrl.abort === 1'b1) n_abort++;
        if (wake === 1'b1) n_wake++;
        if (conv_done_i === 1'b1) n_done++;
    end

    // ============================================================
    // bus access: hold the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        writedata <= {24'h000000, d};
        write <= wr;
        read <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) n_errors++;
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdc(input string nm, input logic [9:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        `CHK(nm, e, q)
    endtask
    // wait a bounded time for an event counter to move
    task automatic wait_cnt(ref int cnt, input int old);
        int n;
        n = 0;
        while (cnt == old && n < 1000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 1000) n_errors++;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        #300000;
        n_errors++;
        wrap_up();
    end

    // ============================================================
    // main sequence
    initial begin
        {ce, nrst, read, write, sleep_i, address, writedata} = '0;
        ce = 1'b1;
        byteenable = 4'hF;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        `CHK("ctrl_out", 7'h00, conv_ctrl)
        `CHK("port_out", 5'h00, port_cfg)
        rdc("ctrl", A_CTRL, 8'h00);
        rdc("port", A_PORT, 8'h00);
        rdc("flags", A_FLAGS, 8'h00);
        rdc("enables", A_EN, 8'h00);
        rdc("unmapped", 10'h004, 8'h00);
        wr(A_CTRL, 8'h02);
        rdc("ctrl_bit1", A_CTRL, 8'h00);
        wr(A_PORT, 8'h8F);
        rdc("port", A_PORT, 8'h8F);
        `CHK("port_out", 5'h1F, port_cfg)
        wr(A_EN, 8'h40);
        // every channel, the three divided clocks, both justifications
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            ex = {c, 7'h2B};
            wr(A_PORT, {c[0], 7'h0F});
            wr(A_CTRL, {2'(i % 3), c, 3'b101});
            wait_cnt(n_done, n_done);
            repeat (3) @(posedge clk);
            rdc("ctrl", A_CTRL, {2'(i % 3), c, 3'b001});
            rdc("high", A_HIGH, c[0] ? {6'h00, ex[9:8]} : ex[9:2]);
            rdc("low", A_LOW, c[0] ? ex[7:0] : {ex[1:0], 6'h00});
            `CHK("tick_gap", divs[i % 3], gap)
            `CHK("channel_out", c, conv_ctrl.channel)
            rdc("flags", A_FLAGS, 8'h40);
            `CHK("irq", 1'b1, irq)
            wr(A_FLAGS, 8'h40);
            repeat (3) @(posedge clk);
            `CHK("irq_clr", 1'b0, irq)
        end
        // sleep during a divided-clock conversion aborts it
        s0 = n_abort;
        wr(A_CTRL, 8'h85);
        repeat (20) @(posedge clk);
        sleep_i <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("abort", s0 + 1, n_abort)
        `CHK("power_out", 1'b0, conv_ctrl.power)
        sleep_i <= 1'b0;
        rdc("ctrl", A_CTRL, 8'h81);
        // go in sleep with a divided clock waits until sleep ends
        s0 = n_start;
        sleep_i <= 1'b1;
        wr(A_CTRL, 8'h85);
        repeat (20) @(posedge clk);
        `CHK("sleep_hold", s0, n_start)
        rdc("ctrl_go", A_CTRL, 8'h85);
        sleep_i <= 1'b0;
        wait_cnt(n_done, n_done);
        `CHK("wake_start", s0 + 1, n_start)
        // rc clock conversion in sleep wakes the core
        s0 = n_start;
        w0 = n_wake;
        wr(A_CTRL, 8'hC5);
        sleep_i <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("rc_delay", s0, n_start)
        wait_cnt(n_wake, w0);
        `CHK("start", s0 + 1, n_start)
        `CHK("wake", w0 + 1, n_wake)
        sleep_i <= 1'b0;
        rdc("flags", A_FLAGS, 8'h40);
        wr(A_FLAGS, 8'h40);
        // masked: no wake, no interrupt, power bit stays set
        wr(A_EN, 8'h00);
        d0 = n_done;
        w0 = n_wake;
        wr(A_CTRL, 8'hC5);
        sleep_i <= 1'b1;
        wait_cnt(n_done, d0);
        repeat (3) @(posedge clk);
        `CHK("no_wake", w0, n_wake)
        `CHK("irq_masked", 1'b0, irq)
        sleep_i <= 1'b0;
        rdc("ctrl", A_CTRL, 8'hC1);
        rdc("flags", A_FLAGS, 8'h40);
        // a later reset clears control but keeps the result
        nrst <= 1'b0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        rdc("ctrl", A_CTRL, 8'h00);
        rdc("port", A_PORT, 8'h00);
        rdc("high", A_HIGH, 8'h0A);
        rdc("low", A_LOW, 8'hC0);
        wrap_up();
    end
endmodule
